// ---- dtmf_tone_gen.sv ----
/*
 * Dual tone generator: one square wave from the row group and one from
 * the column group, both divided down from the reference tick.
 * Assumes ref_tick is a one-cycle pulse at the tone reference rate and
 * that tone_on and tone_code come from registers on the same clock.
 */
`timescale 1ns/1ps
module dtmf_tone_gen (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset_n,
	// Tone selection.
	input wire logic ref_tick,
	input wire logic tone_on,
	input wire logic [3:0] tone_code,
	// Square wave outputs.
	output logic low_wave,
	output logic high_wave
);
	import phone_pkg::*;

	// ------------------------------------------------------------------
	// Divider selection
	// ------------------------------------------------------------------

	// Picks one of four half periods by a two bit selector.
	function automatic logic [HALF_W-1:0] pick_half(input logic [1:0] sel,
		input logic [HALF_W-1:0] h0, input logic [HALF_W-1:0] h1,
		input logic [HALF_W-1:0] h2, input logic [HALF_W-1:0] h3);
		logic [HALF_W-1:0] r;
		unique case (sel)
			2'h0: r = h0;
			2'h1: r = h1;
			2'h2: r = h2;
			2'h3: r = h3;
		endcase
		return r;
	endfunction : pick_half

	logic [HALF_W-1:0] low_cnt;
	logic [HALF_W-1:0] high_cnt;

	// Upper code pair picks the keypad row, lower pair the column.
	wire [HALF_W-1:0] low_half = pick_half(tone_code[3:2], HALF_ROW0, HALF_ROW1,
		HALF_ROW2, HALF_ROW3); // [R13] [R15]
	wire [HALF_W-1:0] high_half = pick_half(tone_code[1:0], HALF_COL0, HALF_COL1,
		HALF_COL2, HALF_COL3); // [R13] [R15]
	wire low_wrap = ref_tick && (low_cnt == '0);
	wire high_wrap = ref_tick && (high_cnt == '0);
	wire [HALF_W-1:0] next_low_cnt = low_wrap ? low_half - 12'h001 : low_cnt - 12'h001;
	wire [HALF_W-1:0] next_high_cnt = high_wrap ? high_half - 12'h001 : high_cnt - 12'h001;

	// Row group divider; a silenced tone parks the wave low.
	always_ff @(posedge core_clk) begin
		if (!reset_n || !tone_on) begin
			low_cnt <= '0;
			low_wave <= 1'b0;
		end else if (ref_tick) begin
			low_cnt <= next_low_cnt; // [R14]
			low_wave <= low_wave ^ low_wrap;
		end
	end

	// Column group divider.
	always_ff @(posedge core_clk) begin
		if (!reset_n || !tone_on) begin
			high_cnt <= '0;
			high_wave <= 1'b0;
		end else if (ref_tick) begin
			high_cnt <= next_high_cnt; // [R14]
			high_wave <= high_wave ^ high_wrap;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------

	// Row counter reloads a full half period whenever it wraps.
	property p_low_reload;
		@(posedge core_clk) disable iff (!reset_n)
		(tone_on && $past(tone_on) && low_wrap) |=> (low_cnt == $past(low_half) - 12'h001);
	endproperty
	a_low_reload: assert property (p_low_reload) else $error("row divider reload wrong"); // [R15]

	// Column wave toggles only when its counter has wrapped.
	property p_high_toggle;
		@(posedge core_clk) disable iff (!reset_n)
		(tone_on && $past(tone_on) && $changed(high_wave)) |-> $past(high_wrap);
	endproperty
	a_high_toggle: assert property (p_high_toggle) else $error("column wave toggled early"); // [R13]

endmodule : dtmf_tone_gen

// ---- phone_line_dial_control.sv ----
/*
 * Line control and dialing logic of a direct-connect modem: hook and line
 * relays, role and carrier control, ring status and a dual tone dialer,
 * all behind a classic Wishbone slave with 32-bit data.
 * Assumes the host times every dial, wait and hold interval itself and
 * that the ring and remote carrier pins are asynchronous to core_clk.
 */
// Behaviour
// R1: Seize bit one goes off-hook, zero on-hook.
// R2: Host waits two seconds before line connect.
// R3: Role bit zero calls, one answers.
// R4: Carrier always in answer, caller only when received; code sends it in either role only while the carrier bit is set.
// R5: Ring detect status reads low while ringing.
// R6: Host pulses seize bit, then connects later.
// R7: Host clears both bits, waits 3.5 s.
// R8: Host pulse: 60 ms on-hook, 40 ms off.
// R9: Host sends digit pulses, ten for zero.
// R10: Host leaves 650 ms to 3 s between digits.
// R11: Tone dialing uses tone port, not pulses.
// R12: Tone upper nibble zero silences, one enables.
// R13: Lower code nibble maps to keypad digit.
// R14: Tones divided from 3.579545 MHz reference.
// R15: Each digit gives one row, one column tone.
// R16: Host keeps tone timing and cycle minimums.
// R17: Host configures ports in basic mode.
// R18: Host writes mode byte 89h first.
// R19: Host ignores status until power settles.
// R20: Host times intervals with its own tick.
`timescale 1ns/1ps
module phone_line_dial_control (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset_n,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [phone_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Line side inputs, asynchronous.
	input wire logic ring_in_n,
	input wire logic remote_carrier_in,
	// Line side outputs.
	output logic line_seize_bit,
	output logic line_connect_bit,
	output logic reply_side_select,
	output logic carrier_tx_en,
	output logic tone_active,
	output logic tone_low_out,
	output logic tone_high_out
);
	import phone_pkg::*;

	localparam int TICK_GAP_MIN = 27;
	localparam int TICK_GAP_MAX = 28;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	logic ports_ready;
	logic [CTRL_W-1:0] ctrl;
	logic [7:0] tone_reg;
	logic [3:0] tone_code;
	logic ring_s1;
	logic ring_detect_n;
	logic carr_s1;
	logic carrier_rx;
	logic [PHASE_W-1:0] phase_acc;
	logic ref_tick;

	// Requests are taken in the cycle before ack, so each access takes one edge.
	wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
	wire bus_rd = bus_req && !wb_we_i;
	wire hit_tone = wb_adr_i[ADR_W-1:2] == WORD_TONE;
	wire hit_ctrl = wb_adr_i[ADR_W-1:2] == WORD_CTRL;
	wire hit_status = wb_adr_i[ADR_W-1:2] == WORD_STATUS;
	wire hit_mode = wb_adr_i[ADR_W-1:2] == WORD_MODE;
	wire wr_mode_cfg = bus_wr && hit_mode && (wb_dat_i[7:0] == PORT_MODE_CFG);
	wire wr_tone = bus_wr && hit_tone && ports_ready;
	wire wr_ctrl = bus_wr && hit_ctrl && ports_ready;
	wire tone_req_on = wb_dat_i[7:4] == TONE_ON_NIBBLE;
	wire [7:0] status_byte = {6'h00, carrier_rx, ring_detect_n};
	wire [7:0] rd_byte = hit_tone ? tone_reg :
		hit_ctrl ? {4'h0, ctrl} :
		hit_status ? status_byte :
		hit_mode ? {7'h00, ports_ready} : 8'h00;

	// Single cycle acknowledge; read data is registered with it.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------------
	// Port mode, control and tone registers
	// ------------------------------------------------------------------

	// Mode setup clears every output port, so the line is dropped on it.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ports_ready <= 1'b0;
			ctrl <= CTRL_RESET;
			tone_reg <= TONE_RESET;
			tone_code <= 4'h0;
			tone_active <= 1'b0;
		end else if (wr_mode_cfg) begin
			ports_ready <= 1'b1;
			ctrl <= CTRL_RESET;
			tone_reg <= TONE_RESET;
			tone_code <= 4'h0;
			tone_active <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl <= wb_dat_i[CTRL_W-1:0]; // [R1] [R3]
			end
			if (wr_tone) begin
				tone_reg <= wb_dat_i[7:0];
				tone_code <= wb_dat_i[3:0]; // [R13]
				tone_active <= tone_req_on; // [R12]
			end
		end
	end

	// Relay and role outputs follow the control register one edge later.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			line_seize_bit <= 1'b0;
			line_connect_bit <= 1'b0;
			reply_side_select <= 1'b0;
			carrier_tx_en <= 1'b0;
		end else begin
			line_seize_bit <= ctrl[CTRL_SEIZE_BIT]; // [R1]
			line_connect_bit <= ctrl[CTRL_CONNECT_BIT];
			reply_side_select <= ctrl[CTRL_REPLY_BIT]; // [R3]
			carrier_tx_en <= ctrl[CTRL_CARRIER_BIT] &&
				(ctrl[CTRL_REPLY_BIT] || carrier_rx); // [R4]
		end
	end

	// ------------------------------------------------------------------
	// Line input synchronisers
	// ------------------------------------------------------------------

	// Two flops on each pin; only the second is read.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ring_s1 <= 1'b1;
			ring_detect_n <= 1'b1;
			carr_s1 <= 1'b0;
			carrier_rx <= 1'b0;
		end else begin
			ring_s1 <= ring_in_n;
			ring_detect_n <= ring_s1; // [R5]
			carr_s1 <= remote_carrier_in;
			carrier_rx <= carr_s1;
		end
	end

	// ------------------------------------------------------------------
	// Tone reference tick and generator
	// ------------------------------------------------------------------
	wire [PHASE_W:0] phase_sum = {1'b0, phase_acc} + {1'b0, PHASE_INC};

	// Fractional divider: carry out is a tick at the reference rate.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			phase_acc <= '0;
			ref_tick <= 1'b0;
		end else begin
			phase_acc <= phase_sum[PHASE_W-1:0];
			ref_tick <= phase_sum[PHASE_W]; // [R14]
		end
	end

	dtmf_tone_gen u_tone (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.ref_tick(ref_tick),
		.tone_on(tone_active),
		.tone_code(tone_code),
		.low_wave(tone_low_out),
		.high_wave(tone_high_out)
	);

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	logic [5:0] tick_gap;
	logic tick_seen;

	// Counts cycles between reference ticks for the rate check.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			tick_gap <= 6'h00;
			tick_seen <= 1'b0;
		end else if (ref_tick) begin
			tick_gap <= 6'h01;
			tick_seen <= 1'b1;
		end else if (tick_gap != 6'h3f) begin
			tick_gap <= tick_gap + 6'h01;
		end
	end

	sequence s_ctrl_write;
		wr_ctrl && !wr_mode_cfg;
	endsequence

	property p_seize;
		@(posedge core_clk) disable iff (!reset_n)
		s_ctrl_write |-> ##2 (line_seize_bit == $past(wb_dat_i[CTRL_SEIZE_BIT], 2));
	endproperty
	a_seize: assert property (p_seize) else $error("seize output missed write"); // [R1]

	property p_role;
		@(posedge core_clk) disable iff (!reset_n)
		s_ctrl_write |-> ##2 (reply_side_select == $past(wb_dat_i[CTRL_REPLY_BIT], 2));
	endproperty
	a_role: assert property (p_role) else $error("role output missed write"); // [R3]

	property p_carrier;
		@(posedge core_clk) disable iff (!reset_n)
		carrier_tx_en |-> $past(ctrl[CTRL_CARRIER_BIT]) &&
			($past(ctrl[CTRL_REPLY_BIT]) || $past(carrier_rx));
	endproperty
	a_carrier: assert property (p_carrier) else $error("carrier sent without cause"); // [R4]

	property p_ring;
		@(posedge core_clk) disable iff (!reset_n)
		(!ring_in_n) [*3] |=> !ring_detect_n;
	endproperty
	a_ring: assert property (p_ring) else $error("ring not shown in status"); // [R5]

	property p_tone_off;
		@(posedge core_clk) disable iff (!reset_n)
		(wr_tone && (wb_dat_i[7:4] == TONE_OFF_NIBBLE)) |=> !tone_active ##1 !tone_low_out;
	endproperty
	a_tone_off: assert property (p_tone_off) else $error("tone not silenced"); // [R12]

	property p_tick_rate;
		@(posedge core_clk) disable iff (!reset_n)
		(ref_tick && tick_seen) |-> (tick_gap >= 6'(TICK_GAP_MIN)) && (tick_gap <= 6'(TICK_GAP_MAX));
	endproperty
	a_tick_rate: assert property (p_tick_rate) else $error("reference tick rate off"); // [R14]

endmodule : phone_line_dial_control

// ---- phone_line_model.sv ----
/*
 * Behavioural telephone line facing the modem: ring detector and remote
 * carrier detector pins, driven asynchronously to the core clock.
 * Assumes the bench commands ringing and remote carrier by level.
 */
`timescale 1ns/1ps
module phone_line_model (
	// Commands from the bench.
	input wire logic ring_req,
	input wire logic carrier_req,
	// Line detector pins.
	output logic ring_in_n,
	output logic remote_carrier_in
);
	// ----------------------------------------------------------------
	// Detector pins
	// ----------------------------------------------------------------
	// Odd delays keep the pin edges away from the core clock edges.
	// Continuous drive so the pins hold a known level from 7 ns on.
	assign #7 ring_in_n = ~ring_req;
	assign #3 remote_carrier_in = carrier_req;
endmodule : phone_line_model

// ---- phone_pkg.sv ----
/*
 * Shared constants of the phone line dial control block: register word
 * indices, control and status field positions, tone port encodings and
 * the clock and tone divider figures.
 * Assumes a 100 MHz core clock and a 32-bit classic Wishbone register bus.
 */
package phone_pkg;

	// ------------------------------------------------------------------
	// Clocks and reference divider
	// ------------------------------------------------------------------
	localparam longint CORE_HZ = 100_000_000;
	localparam longint TONE_REF_HZ = 3_579_545;
	localparam int PHASE_W = 24;
	localparam logic [63:0] PHASE_INC_WIDE = (64'(TONE_REF_HZ) << PHASE_W) / 64'(CORE_HZ);
	localparam logic [PHASE_W-1:0] PHASE_INC = PHASE_INC_WIDE[PHASE_W-1:0];

	// ------------------------------------------------------------------
	// Register map: word indices, byte address is four times the index
	// ------------------------------------------------------------------
	localparam int ADR_W = 12;
	localparam logic [7:0] IDX_TONE = 8'h84;
	localparam logic [7:0] IDX_CTRL = 8'h85;
	localparam logic [7:0] IDX_STATUS = 8'h86;
	localparam logic [7:0] IDX_MODE = 8'h87;
	localparam logic [9:0] WORD_TONE = {2'h0, IDX_TONE};
	localparam logic [9:0] WORD_CTRL = {2'h0, IDX_CTRL};
	localparam logic [9:0] WORD_STATUS = {2'h0, IDX_STATUS};
	localparam logic [9:0] WORD_MODE = {2'h0, IDX_MODE};

	// ------------------------------------------------------------------
	// Field layouts and values
	// ------------------------------------------------------------------
	localparam int CTRL_SEIZE_BIT = 0;
	localparam int CTRL_CONNECT_BIT = 1;
	localparam int CTRL_REPLY_BIT = 2;
	localparam int CTRL_CARRIER_BIT = 3;
	localparam int CTRL_W = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
	localparam int STATUS_RING_BIT = 0;
	localparam int STATUS_CARRIER_BIT = 1;
	localparam logic [3:0] TONE_OFF_NIBBLE = 4'h0;
	localparam logic [3:0] TONE_ON_NIBBLE = 4'h1;
	localparam logic [7:0] TONE_RESET = 8'h00;
	localparam logic [7:0] PORT_MODE_CFG = 8'h89;

	// ------------------------------------------------------------------
	// Tone half periods in reference clock ticks (row and column groups)
	// ------------------------------------------------------------------
	localparam int HALF_W = 12;
	localparam logic [HALF_W-1:0] HALF_ROW0 = 12'h9f8; // 2552 ticks, about 701 Hz.
	localparam logic [HALF_W-1:0] HALF_ROW1 = 12'h910; // 2320 ticks, about 771 Hz.
	localparam logic [HALF_W-1:0] HALF_ROW2 = 12'h828; // 2088 ticks, about 857 Hz.
	localparam logic [HALF_W-1:0] HALF_ROW3 = 12'h77a; // 1914 ticks, about 935 Hz.
	localparam logic [HALF_W-1:0] HALF_COL0 = 12'h5c0; // 1472 ticks, about 1216 Hz.
	localparam logic [HALF_W-1:0] HALF_COL1 = 12'h540; // 1344 ticks, about 1332 Hz.
	localparam logic [HALF_W-1:0] HALF_COL2 = 12'h4c0; // 1216 ticks, about 1472 Hz.
	localparam logic [HALF_W-1:0] HALF_COL3 = 12'h440; // 1088 ticks, about 1645 Hz.

endpackage : phone_pkg

// ---- tb_phone_line_dial_control.sv ----
/*
 * Self-checking bench of the line control and tone dialer block.
 * Assumes phone_pkg and a registered Wishbone slave with one-cycle ack.
 */
`timescale 1ns/1ps
module tb_phone_line_dial_control;
	import phone_pkg::*;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic core_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ring_req, carrier_req;
	logic [ADR_W-1:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic ring_in_n, remote_carrier_in, line_seize_bit, line_connect_bit, reply_side_select;
	logic carrier_tx_en, tone_active, tone_low_out, tone_high_out;
	logic [15:0] lfsr;
	int bad_count, check_count, cycles;
	int falls, f0, digit;
	real t0, t1, lo, hi;
	localparam logic [ADR_W-1:0] A_TONE = {WORD_TONE, 2'b00};
	localparam logic [ADR_W-1:0] A_CTRL = {WORD_CTRL, 2'b00};
	localparam logic [ADR_W-1:0] A_STAT = {WORD_STATUS, 2'b00};
	localparam logic [ADR_W-1:0] A_MODE = {WORD_MODE, 2'b00};

	phone_line_dial_control DUT (.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ring_in_n(ring_in_n),
		.remote_carrier_in(remote_carrier_in), .line_seize_bit(line_seize_bit),
		.line_connect_bit(line_connect_bit), .reply_side_select(reply_side_select),
		.carrier_tx_en(carrier_tx_en), .tone_active(tone_active), .tone_low_out(tone_low_out),
		.tone_high_out(tone_high_out));
	phone_line_model line (.ring_req(ring_req), .carrier_req(carrier_req),
		.ring_in_n(ring_in_n), .remote_carrier_in(remote_carrier_in));
	// Counts seize bit falls, one per dial pulse on the line.
	always @(negedge line_seize_bit) falls++;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Sixteen-bit Fibonacci shift register for repeatable stimulus.
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	// Caller role sends only while the far carrier is heard.
	function automatic logic exp_carrier(input logic [3:0] c, input logic remote);
		return c[3] & (c[2] | remote);
	endfunction : exp_carrier
	// Pulses per dialed digit: the digit itself, ten for zero.
	function automatic int pulse_count(input int d);
		return (d == 0) ? 10 : d;
	endfunction : pulse_count
	// Host millisecond, shortened to one clock so second-long waits fit the run.
	task automatic wait_ms(input int ms);
		repeat (ms) @(posedge core_clk);
	endtask : wait_ms
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : check
	// Half period in ns of tone f must sit within 1.5 percent.
	task automatic check_half(input real got, input real f, input string what);
		check_count++;
		if (got < 0.985 * 5.0e8 / f || got > 1.015 * 5.0e8 / f) begin
			bad_count++;
			$display("unexpected at %0t: %s half period %f ns", $time, what, got);
		end
	endtask : check_half
	// Classic single cycle, called just after a rising edge; the request stands until
	// ack is sampled high at a rising edge, read data is taken there, then one idle cycle.
	task automatic bus(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] dat);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do begin
			@(posedge core_clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge core_clk);
	endtask : bus

	// ----------------------------------------------------------------
	// Clock and timeout
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 90000) begin
			bad_count++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{reset_n, wb_cyc_i, wb_stb_i, wb_we_i, ring_req, carrier_req} = 6'h0;
		wb_adr_i = '0;
		wb_sel_i = 4'hf;
		wb_dat_i = '0;
		lfsr = 16'ha790;
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		bus(1'b1, A_CTRL, 32'h0f);
		check({31'h0, line_seize_bit}, 32'h0, "ctrl before setup");
		bus(1'b1, A_MODE, 32'h88);
		bus(1'b0, A_MODE, 32'h0);
		check(rd, 32'h0, "bad mode byte");
		bus(1'b1, A_MODE, {24'h0, PORT_MODE_CFG});
		bus(1'b0, A_MODE, 32'h0);
		check(rd, 32'h1, "mode ready");
		bus(1'b1, A_CTRL, 32'h1);
		check({31'h0, line_seize_bit}, 32'h1, "off hook");
		// Random control words with a random far carrier level set before each.
		for (int i = 0; i < 16; i++) begin
			lfsr = lfsr_next(lfsr);
			carrier_req <= lfsr[4];
			repeat (6) @(posedge core_clk);
			bus(1'b1, A_CTRL, {28'h0, lfsr[3:0]});
			check({28'h0, carrier_tx_en, reply_side_select, line_connect_bit, line_seize_bit},
				{28'h0, exp_carrier(lfsr[3:0], lfsr[4]), lfsr[2:0]}, "ctrl");
			bus(1'b0, A_CTRL, 32'h0);
			check(rd, {28'h0, lfsr[3:0]}, "ctrl read");
		end
		// Pulse dial two random digits on the seize bit, then connect and hang up.
		bus(1'b1, A_CTRL, 32'h1);
		wait_ms(2000);
		for (int d = 0; d < 2; d++) begin
			lfsr = lfsr_next(lfsr);
			digit = int'(lfsr[3:0]) % 10;
			f0 = falls;
			repeat (pulse_count(digit)) begin
				bus(1'b1, A_CTRL, 32'h0);
				wait_ms(57); // Three clocks of the write make it 60.
				bus(1'b1, A_CTRL, 32'h1);
				wait_ms(37); // Three clocks of the write make it 40.
			end
			check(falls - f0, pulse_count(digit), "dial pulses");
			wait_ms(650);
		end
		wait_ms(1350);
		bus(1'b1, A_CTRL, 32'h3);
		check({30'h0, line_connect_bit, line_seize_bit}, 32'h3, "connected");
		bus(1'b1, A_CTRL, 32'h0);
		check({30'h0, line_connect_bit, line_seize_bit}, 32'h0, "hung up");
		wait_ms(3501);
		// Ringing on then off, read through status once the status is trusted.
		wait_ms(100);
		for (int r = 1; r >= 0; r--) begin
			ring_req <= r[0];
			repeat (10) @(posedge core_clk);
			bus(1'b0, A_STAT, 32'h0);
			check(rd, {30'h0, carrier_req, ~r[0]}, "status");
		end
		bus(1'b1, 12'h004, 32'hff);
		bus(1'b0, 12'h004, 32'h0);
		check(rd, 32'h0, "unmapped read");
		// Every tone code enables with host tone timing; zero and a foreign nibble silence.
		bus(1'b1, A_CTRL, 32'h3);
		for (int c = 0; c < 16; c++) begin
			bus(1'b1, A_TONE, {24'h0, TONE_ON_NIBBLE, c[3:0]});
			check({31'h0, tone_active}, 32'h1, "tone on");
			wait_ms(50);
			bus(1'b1, A_TONE, 32'h00);
			wait_ms(50);
		end
		bus(1'b1, A_TONE, 32'h15);
		bus(1'b1, A_TONE, 32'h00);
		check({29'h0, tone_active, tone_low_out, tone_high_out}, 32'h0, "tone off");
		bus(1'b1, A_TONE, 32'h15);
		bus(1'b1, A_TONE, 32'h2f);
		check({31'h0, tone_active}, 32'h0, "foreign nibble");
		// Code F selects the last row and last column group.
		bus(1'b1, A_TONE, 32'h1f);
		fork
			begin
				@(tone_low_out);
				t0 = $realtime;
				@(tone_low_out);
				lo = $realtime - t0;
			end
			begin
				@(tone_high_out);
				t1 = $realtime;
				@(tone_high_out);
				hi = $realtime - t1;
			end
		join
		check_half(lo, 941.0, "row");
		check_half(hi, 1633.0, "column");
		print_verdict();
	end
endmodule : tb_phone_line_dial_control
